// ### rtl/ufi_pkg.sv
// shared constants and carrier types for the usb function interrupt block
package ufi_pkg;
   // ********************
   // sizes and bit positions
   // ********************
   localparam int NUM_EP = 7;
   localparam int NUM_SRC = 11;
   localparam logic [2:0] EP_LAST = 3'h6;
   localparam logic [2:0] EP_CTRL = 3'h0;
   localparam int IB_SOF = 7;
   localparam int IB_WAKE = 8;
   localparam int IB_RSM = 9;
   localparam int IB_SUSPEND_EVENT = 10;
   localparam logic [10:0] FW_CLEAR_MASK = 11'h300;
   localparam logic [10:0] ACK_CLEAR_MASK = 11'h0FF;
   localparam logic [10:0] EP_MASK = 11'h07F;
   localparam logic [1:0] PRIO_NONE = 2'h0;
   localparam logic [1:0] PRIO_EP = 2'h1;
   localparam logic [1:0] PRIO_SOF = 2'h2;

   // ********************
   // register map, byte addresses
   // ********************
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_ENABLE = 8'h04;
   localparam logic [7:0] ADDR_ACK = 8'h08;
   localparam logic [7:0] ADDR_PRIO = 8'h0C;
   localparam logic [7:0] ADDR_TOKEN = 8'h10;
   localparam logic [7:0] ADDR_CSR0 = 8'h20;
   localparam logic [7:0] ADDR_CSR_LAST = 8'h38;
   localparam logic [10:0] RESET_ENABLE = 11'h000;

   // ********************
   // carrier types
   // ********************
   typedef enum logic [1:0] {TOK_NONE, TOK_OUT, TOK_IN, TOK_SETUP} ufi_tok_type;

   // bit 7 down to bit 0 as seen in an endpoint csr word
   typedef struct packed {
      logic toggle;
      logic pingpong;
      logic enable;
      logic dir_in;
      logic tx_done;
      logic tx_ready;
      logic rx_setup;
      logic rx_out;
   } ufi_csr_type;

   typedef struct packed {
      logic token_valid;
      ufi_tok_type token;
      logic [2:0] ep;
      logic data_ok;
      logic in_ack;
      logic in_lost;
      logic sof;
      logic suspend_det;
      logic activity;
      logic resume_det;
      logic wakeup_req;
   } ufi_sie_type;

   typedef struct packed {
      logic ack;
      logic nak;
      logic send;
      logic pid1;
   } ufi_hs_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ufi_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ufi_apb_rsp_type;

   typedef struct packed {
      ufi_csr_type [NUM_EP-1:0] csr;
      logic [NUM_SRC-1:0] pend;
      logic [NUM_SRC-1:0] enab;
      logic [2:0] tok_ep;
      ufi_tok_type tok_kind;
      logic irq;
      logic [1:0] level;
      ufi_hs_type hs;
      ufi_apb_rsp_type rsp;
   } ufi_state_type;
endpackage

// ### rtl/ufi_irq_ctrl.sv
// usb function interrupt aggregation, endpoint flags and apb register file
//
// How it works
// - all usb sources merge into one interrupt output to the processor
// - each source gated by its own enable bit; disabled sources never interrupt
// - remote wake-up and resume bits stay set until firmware clears them
// - suspend bit clears itself when bus activity returns
// - other bits clear only by writing one to the acknowledge register
// - each source owns one status and enable bit; only endpoint and frame sources (bits 0 to 7) have an acknowledge bit
// - out endpoint interrupts after a valid out packet lands in buffer
// - in endpoint interrupts after in token, data sent and host ack
// - every valid start-of-frame raises the frame interrupt
// - a remote wake-up request raises the wake-up interrupt
// - detected resume signalling raises the resume interrupt for firmware
// - detected bus suspend raises the suspend interrupt for firmware
// - frame interrupt has level 2; all seven endpoints share level 1
// - data endpoints interrupt on out flag rising or in-ready falling
// - control endpoint also interrupts on setup rising or in-done rising
// - a disabled endpoint stays in receive mode until reconfigured
// - valid tokens are reported and following data goes to the buffer
// - one packet per endpoint at a time; busy buffers refuse out tokens, but an enabled control endpoint accepts every setup
// - unacknowledged data is resent and data pid toggles on success
// - serial engine checks crc, stuffing, nrzi, address and token type
`timescale 1ns/1ps
module ufi_irq_ctrl
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire ufi_pkg::ufi_apb_req_type apb_req,
   output ufi_pkg::ufi_apb_rsp_type apb_rsp,
   input wire ufi_pkg::ufi_sie_type sie_ev,
   output ufi_pkg::ufi_hs_type hs,
   output logic irq,
   output logic [1:0] irq_level
);
   import ufi_pkg::*;

   // ********************
   // decode helpers
   // ********************
   function automatic logic is_csr(input logic [7:0] a);
      return (a >= ADDR_CSR0) && (a <= ADDR_CSR_LAST) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [2:0] csr_idx(input logic [7:0] a);
      logic [7:0] off;
      off = a - ADDR_CSR0;
      return off[4:2];
   endfunction

   // a receive buffer may take a packet only when enabled, out-facing and empty
   function automatic logic rx_free(input ufi_csr_type c);
      return c.enable && !c.dir_in && !c.rx_out && !c.rx_setup;
   endfunction

   ufi_state_type st_q;
   ufi_state_type st_d;

   logic wr_access;
   logic ep_ok;
   assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite && st_q.rsp.pready;
   assign ep_ok = sie_ev.ep <= EP_LAST;

   // ********************
   // next state
   // ********************
   always_comb
   begin
      ufi_csr_type [NUM_EP-1:0] old;
      ufi_csr_type w;
      logic [NUM_SRC-1:0] set_v;
      logic [NUM_SRC-1:0] clr_v;
      logic [7:0] a;
      old = st_q.csr;
      w = ufi_csr_type'(apb_req.pwdata[7:0]);
      set_v = '0;
      clr_v = '0;
      a = apb_req.paddr;
      st_d = st_q;
      st_d.hs = '0;

      // register writes go first so a same-cycle hardware event wins
      if (wr_access)
      begin
         if (a == ADDR_ENABLE)
         begin
            st_d.enab = apb_req.pwdata[NUM_SRC-1:0];
         end
         if (a == ADDR_ACK)
         begin
            clr_v = clr_v | (apb_req.pwdata[NUM_SRC-1:0] & ACK_CLEAR_MASK);
         end
         if (a == ADDR_STATUS)
         begin
            clr_v = clr_v | (apb_req.pwdata[NUM_SRC-1:0] & FW_CLEAR_MASK);
         end
         if (is_csr(a))
         begin
            // firmware enables, sets direction and ping-pong here
            st_d.csr[csr_idx(a)].enable = w.enable;
            st_d.csr[csr_idx(a)].dir_in = w.dir_in && w.enable;
            st_d.csr[csr_idx(a)].pingpong = w.pingpong;
            if (w.rx_out)
            begin
               st_d.csr[csr_idx(a)].rx_out = 1'b0;
            end
            if (w.rx_setup)
            begin
               st_d.csr[csr_idx(a)].rx_setup = 1'b0;
            end
            if (w.tx_done)
            begin
               st_d.csr[csr_idx(a)].tx_done = 1'b0;
            end
            if (w.tx_ready)
            begin
               st_d.csr[csr_idx(a)].tx_ready = 1'b1;
            end
         end
      end

      // token handshake; engine only forwards tokens already checked
      if (sie_ev.token_valid && ep_ok)
      begin
         st_d.tok_ep = sie_ev.ep;
         st_d.tok_kind = sie_ev.token;
         unique case (sie_ev.token)
            TOK_OUT:
            begin
               st_d.hs.ack = rx_free(st_q.csr[sie_ev.ep]);
               st_d.hs.nak = !rx_free(st_q.csr[sie_ev.ep]);
            end
            TOK_IN:
            begin
               // an unacked packet keeps tx_ready, so the next in resends it
               st_d.hs.send = st_q.csr[sie_ev.ep].enable && st_q.csr[sie_ev.ep].dir_in
                  && st_q.csr[sie_ev.ep].tx_ready;
               st_d.hs.nak = !st_d.hs.send;
               st_d.hs.pid1 = st_q.csr[sie_ev.ep].toggle;
            end
            TOK_SETUP:
            begin
               st_d.hs.ack = (sie_ev.ep == EP_CTRL) && st_q.csr[EP_CTRL].enable;
            end
            TOK_NONE:
            begin
            end
         endcase
      end

      // data packet stored; a setup accepted on the enabled control endpoint restarts the toggle at data1
      if (sie_ev.data_ok && ep_ok)
      begin
         if (sie_ev.token == TOK_SETUP && sie_ev.ep == EP_CTRL && st_q.csr[EP_CTRL].enable)
         begin
            st_d.csr[EP_CTRL].rx_setup = 1'b1;
            st_d.csr[EP_CTRL].toggle = 1'b1;
         end
         else if (sie_ev.token == TOK_OUT && rx_free(st_q.csr[sie_ev.ep]))
         begin
            st_d.csr[sie_ev.ep].rx_out = 1'b1;
            st_d.csr[sie_ev.ep].toggle = !st_q.csr[sie_ev.ep].toggle;
         end
      end

      // host acknowledged in data: buffer is writable again
      if (sie_ev.in_ack && ep_ok && st_q.csr[sie_ev.ep].tx_ready)
      begin
         st_d.csr[sie_ev.ep].tx_ready = 1'b0;
         st_d.csr[sie_ev.ep].toggle = !st_q.csr[sie_ev.ep].toggle;
         if (sie_ev.ep == EP_CTRL)
         begin
            st_d.csr[EP_CTRL].tx_done = 1'b1;
         end
      end

      // endpoint flag edges become interrupt events
      for (int i = 0; i < NUM_EP; i++)
      begin
         set_v[i] = (!old[i].rx_out && st_d.csr[i].rx_out)
            || (old[i].tx_ready && !st_d.csr[i].tx_ready);
         if (i == 0)
         begin
            set_v[i] = set_v[i] || (!old[i].rx_setup && st_d.csr[i].rx_setup)
               || (!old[i].tx_done && st_d.csr[i].tx_done);
         end
      end
      set_v[IB_SOF] = sie_ev.sof;
      set_v[IB_WAKE] = sie_ev.wakeup_req;
      set_v[IB_RSM] = sie_ev.resume_det;
      set_v[IB_SUSPEND_EVENT] = sie_ev.suspend_det;
      if (sie_ev.activity)
      begin
         clr_v[IB_SUSPEND_EVENT] = 1'b1;
      end
      st_d.pend = (st_q.pend & ~clr_v) | set_v;

      st_d.irq = |(st_d.pend & st_d.enab);
      if (st_d.pend[IB_SOF] && st_d.enab[IB_SOF])
      begin
         st_d.level = PRIO_SOF;
      end
      else if (|(st_d.pend & st_d.enab & EP_MASK))
      begin
         st_d.level = PRIO_EP;
      end
      else
      begin
         st_d.level = PRIO_NONE;
      end

      // ********************
      // apb read side, data captured in the setup cycle
      // ********************
      // one wait-free access: pready rises the cycle after setup
      st_d.rsp = '0;
      if (apb_req.psel && !apb_req.penable)
      begin
         st_d.rsp.pready = 1'b1;
         if (is_csr(a))
         begin
            st_d.rsp.prdata = {24'h000000, st_q.csr[csr_idx(a)]};
         end
         else
         begin
            unique case (a)
               ADDR_STATUS: st_d.rsp.prdata = {21'h00000, st_q.pend};
               ADDR_ENABLE: st_d.rsp.prdata = {21'h00000, st_q.enab};
               ADDR_ACK: st_d.rsp.prdata = 32'h00000000;
               ADDR_PRIO: st_d.rsp.prdata = {30'h0000000, st_q.level};
               ADDR_TOKEN: st_d.rsp.prdata = {27'h000000, st_q.tok_kind, st_q.tok_ep};
               default: st_d.rsp.pslverr = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign apb_rsp = st_q.rsp;
   assign hs = st_q.hs;
   assign irq = st_q.irq;
   assign irq_level = st_q.level;

   // ********************
   // assertions
   // ********************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   logic ack_sof_wr;
   logic fw_wake_wr;
   assign ack_sof_wr = wr_access && apb_req.paddr == ADDR_ACK && apb_req.pwdata[IB_SOF];
   assign fw_wake_wr = wr_access && apb_req.paddr == ADDR_STATUS && apb_req.pwdata[IB_WAKE];

   sequence s_apb_setup;
      apb_req.psel && !apb_req.penable;
   endsequence
   sequence s_out_busy;
      sie_ev.token_valid && sie_ev.token == TOK_OUT && sie_ev.ep == 3'h1 && st_q.csr[1].rx_out;
   endsequence

   property p_irq_or;
      irq == |(st_q.pend & st_q.enab);
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("irq not the or of enabled pending");

   property p_mask;
      (st_q.enab == '0) |-> !irq;
   endproperty
   a_mask: assert property (p_mask) else $error("masked source drove irq");

   property p_wake_hold;
      (st_q.pend[IB_WAKE] && !fw_wake_wr) |=> st_q.pend[IB_WAKE];
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("wake-up bit lost");

   property p_suspend_event_clear;
      (sie_ev.activity && !sie_ev.suspend_det) |=> !st_q.pend[IB_SUSPEND_EVENT];
   endproperty
   a_suspend_event_clear: assert property (p_suspend_event_clear) else $error("suspend not cleared");

   property p_ack_clear;
      (ack_sof_wr && !sie_ev.sof) |=> !st_q.pend[IB_SOF] ##1 (!st_q.pend[IB_SOF] || $past(sie_ev.sof));
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear frame bit");

   property p_sof;
      sie_ev.sof |=> st_q.pend[IB_SOF] && (st_q.enab[IB_SOF] == irq_level[1]);
   endproperty
   a_sof: assert property (p_sof) else $error("frame interrupt missing");

   property p_out_edge;
      $rose(st_q.csr[1].rx_out) |-> st_q.pend[1];
   endproperty
   a_out_edge: assert property (p_out_edge) else $error("out packet raised no interrupt");

   property p_in_edge;
      $fell(st_q.csr[2].tx_ready) |-> st_q.pend[2];
   endproperty
   a_in_edge: assert property (p_in_edge) else $error("in completion raised no interrupt");

   property p_nak_busy;
      s_out_busy |=> hs.nak && !hs.ack;
   endproperty
   a_nak_busy: assert property (p_nak_busy) else $error("busy buffer not refused");

   property p_toggle;
      (sie_ev.in_ack && sie_ev.ep == 3'h2 && st_q.csr[2].tx_ready)
         |=> st_q.csr[2].toggle != $past(st_q.csr[2].toggle);
   endproperty
   a_toggle: assert property (p_toggle) else $error("data pid did not toggle");

   property p_rx_default;
      !st_q.csr[4].enable |-> !st_q.csr[4].dir_in;
   endproperty
   a_rx_default: assert property (p_rx_default) else $error("disabled endpoint not in receive");

   property p_apb_ready;
      s_apb_setup |=> apb_rsp.pready ##1 !apb_rsp.pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong");

   property p_rsm_hold;
      (st_q.pend[IB_RSM]
         && !(wr_access && apb_req.paddr == ADDR_STATUS && apb_req.pwdata[IB_RSM]))
         |=> st_q.pend[IB_RSM];
   endproperty
   a_rsm_hold: assert property (p_rsm_hold) else $error("resume bit lost");

   property p_wake_set;
      sie_ev.wakeup_req |=> st_q.pend[IB_WAKE];
   endproperty
   a_wake_set: assert property (p_wake_set) else $error("wake-up request not latched");

   property p_rsm_set;
      sie_ev.resume_det |=> st_q.pend[IB_RSM];
   endproperty
   a_rsm_set: assert property (p_rsm_set) else $error("resume signalling not latched");

   property p_suspend_event_set;
      sie_ev.suspend_det |=> st_q.pend[IB_SUSPEND_EVENT];
   endproperty
   a_suspend_event_set: assert property (p_suspend_event_set) else $error("suspend not latched");

   property p_ep_level;
      (|(st_q.pend & st_q.enab & EP_MASK) && !(st_q.pend[IB_SOF] && st_q.enab[IB_SOF]))
         |-> irq_level == PRIO_EP;
   endproperty
   a_ep_level: assert property (p_ep_level) else $error("endpoint level wrong");

   property p_setup_edge;
      $rose(st_q.csr[0].rx_setup) |-> st_q.pend[0];
   endproperty
   a_setup_edge: assert property (p_setup_edge) else $error("setup raised no interrupt");

   property p_token_kept;
      (sie_ev.token_valid && sie_ev.ep == 3'h2) |=> st_q.tok_ep == 3'h2;
   endproperty
   a_token_kept: assert property (p_token_kept) else $error("token endpoint not kept");
endmodule // ufi_irq_ctrl

// ### sim/ufi_host_model.sv
// behavioural host side: serial engine event pulses towards the block
`timescale 1ns/1ps
module ufi_host_model
(
   input wire logic ref_clk,
   output ufi_pkg::ufi_sie_type sie_ev
);
   import ufi_pkg::*;
   initial sie_ev = '0;

   // ********************
   // event pulses
   // ********************
   // one cycle high; returns at the edge that samples it, so never held longer
   task automatic strobe(input ufi_sie_type v);
      @(posedge ref_clk);
      sie_ev <= v;
      @(posedge ref_clk);
      sie_ev <= '0;
   endtask

   task automatic token(input ufi_tok_type k, input logic [2:0] ep);
      ufi_sie_type v;
      v = '0;
      v.token_valid = 1'b1;
      v.token = k;
      v.ep = ep;
      strobe(v);
   endtask

   // data follows its token, as the host orders them
   task automatic data(input ufi_tok_type k, input logic [2:0] ep);
      ufi_sie_type v;
      v = '0;
      v.data_ok = 1'b1;
      v.token = k;
      v.ep = ep;
      strobe(v);
   endtask

   task automatic ack_in(input logic [2:0] ep);
      ufi_sie_type v;
      v = '0;
      v.in_ack = 1'b1;
      v.ep = ep;
      strobe(v);
   endtask

   // 0 frame, 1 wake-up, 2 resume, 3 suspend, 4 activity
   task automatic bus(input int s);
      ufi_sie_type v;
      v = '0;
      v.sof = (s == 0);
      v.wakeup_req = (s == 1);
      v.resume_det = (s == 2);
      v.suspend_det = (s == 3);
      v.activity = (s == 4);
      strobe(v);
   endtask
endmodule // ufi_host_model

// ### sim/usb_function_interrupt_logic_test.sv
// self-checking bench for the usb function interrupt block
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         n_fail++; \
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module usb_function_interrupt_logic_test;
   import ufi_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   ufi_apb_req_type apb_req = '0;
   ufi_apb_rsp_type apb_rsp;
   ufi_sie_type sie_ev;
   ufi_hs_type hs;
   logic irq;
   logic [1:0] irq_level;
   logic [31:0] rd;
   logic err;
   int n_fail = 0;
   int cmp_count = 0;

   always #10 ref_clk = ~ref_clk;

   ufi_irq_ctrl dut_u (.ref_clk(ref_clk), .reset(reset), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .sie_ev(sie_ev), .hs(hs), .irq(irq), .irq_level(irq_level));
   ufi_host_model host_u (.ref_clk(ref_clk), .sie_ev(sie_ev));

   // ********************
   // bus tasks
   // ********************
   // waits on pready with a bound instead of assuming the slave's latency
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge ref_clk);
      apb_req.penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (apb_rsp.pready !== 1'b1 && n < 20);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      `CHK("pready", 1'b1, apb_rsp.pready)
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd);
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd & m)
   endtask

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge ref_clk);
      n_fail++;
      print_verdict();
   end

   // ********************
   // tests
   // ********************
   initial
   begin
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      rdchk("enable", ADDR_ENABLE, 32'h0, 32'hFFFFFFFF);
      `CHK("irq", 1'b0, irq)
      wr(ADDR_ENABLE, 32'h7FF);
      wr(ADDR_CSR0 + 8'h04, 32'h20);
      host_u.token(TOK_OUT, 3'h3);
      #1 `CHK("hs", 4'h4, hs)
      host_u.token(TOK_OUT, 3'h1);
      #1 `CHK("hs", 4'h8, hs)
      host_u.data(TOK_OUT, 3'h1);
      #1 `CHK("irq", 1'b1, irq)
      `CHK("level", 2'h1, irq_level)
      rdchk("status", ADDR_STATUS, 32'h2, 32'hFFFFFFFF);
      rdchk("csr1", ADDR_CSR0 + 8'h04, 32'h21, 32'h7F);
      host_u.token(TOK_OUT, 3'h1);
      #1 `CHK("hs busy", 4'h4, hs)
      wr(ADDR_STATUS, 32'h2);
      rdchk("status", ADDR_STATUS, 32'h2, 32'hFFFFFFFF);
      wr(ADDR_ACK, 32'h2);
      rdchk("status", ADDR_STATUS, 32'h0, 32'hFFFFFFFF);
      `CHK("irq", 1'b0, irq)
      // frame source masked first, then unmasked while still pending
      wr(ADDR_ENABLE, 32'h07F);
      host_u.bus(0);
      #1 `CHK("irq", 1'b0, irq)
      rdchk("status", ADDR_STATUS, 32'h80, 32'hFFFFFFFF);
      wr(ADDR_ENABLE, 32'h7FF);
      rdchk("prio", ADDR_PRIO, 32'h2, 32'hFFFFFFFF);
      `CHK("irq", 1'b1, irq)
      `CHK("level", 2'h2, irq_level)
      wr(ADDR_ACK, 32'h80);
      rdchk("status", ADDR_STATUS, 32'h0, 32'hFFFFFFFF);
      for (int i = 0; i < 2; i++)
      begin
         host_u.bus(i + 1);
         #1 `CHK("irq", 1'b1, irq)
         wr(ADDR_ACK, 32'h300);
         rdchk("status", ADDR_STATUS, 32'h100 << i, 32'hFFFFFFFF);
         wr(ADDR_STATUS, 32'h100 << i);
         rdchk("status", ADDR_STATUS, 32'h0, 32'hFFFFFFFF);
      end
      host_u.bus(3);
      #1 `CHK("irq", 1'b1, irq)
      wr(ADDR_ACK, 32'hFF);
      rdchk("status", ADDR_STATUS, 32'h400, 32'hFFFFFFFF);
      host_u.bus(4);
      #1 `CHK("irq", 1'b0, irq)
      // in endpoint twice: data pid must alternate
      wr(ADDR_CSR0 + 8'h08, 32'h30);
      for (int i = 0; i < 2; i++)
      begin
         wr(ADDR_CSR0 + 8'h08, 32'h34);
         host_u.token(TOK_IN, 3'h2);
         #1 `CHK("hs", {3'b001, i[0]}, hs)
         host_u.ack_in(3'h2);
         #1 `CHK("irq", 1'b1, irq)
         rdchk("csr2", ADDR_CSR0 + 8'h08, {24'h0, ~i[0], 7'h30}, 32'hFFFFFFFF);
         wr(ADDR_ACK, 32'h4);
      end
      wr(ADDR_CSR0, 32'h20);
      host_u.token(TOK_SETUP, 3'h1);
      #1 `CHK("hs", 4'h0, hs)
      host_u.token(TOK_SETUP, 3'h0);
      #1 `CHK("hs", 4'h8, hs)
      host_u.data(TOK_SETUP, 3'h0);
      #1 `CHK("level", 2'h1, irq_level)
      rdchk("csr0", ADDR_CSR0, 32'hA2, 32'hFFFFFFFF);
      // firmware clears the setup flag once the request is decoded
      wr(ADDR_CSR0, 32'h22);
      wr(ADDR_ACK, 32'h1);
      rdchk("status", ADDR_STATUS, 32'h0, 32'hFFFFFFFF);
      apb(1'b0, 8'h40, 32'h0);
      `CHK("slverr", 1'b1, err)
      print_verdict();
   end
endmodule // usb_function_interrupt_logic_test
